// ===== hw/bssc_pkg.sv
// Purpose: Shared constants and types for the boot strap and clock select block
// Assumes: 16-bit registers on a 32-bit AHB-Lite data path, one word per register
// Notes: Register indices are kept as printed; byte address is four times the index

package bssc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] CLK_CFG_INDEX = 16'h1C1F;
	localparam logic [15:0] BOOT_STAT_INDEX = 16'h1C34;
	localparam logic [31:0] CLK_CFG_ADDR = {14'h0000, CLK_CFG_INDEX, 2'h0};
	localparam logic [31:0] BOOT_STAT_ADDR = {14'h0000, BOOT_STAT_INDEX, 2'h0};
	localparam int REG_WIDTH = 16;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int BOOT_CODE_LSB = 5;
	localparam int BOOT_CODE_W = 4;
	localparam int CLK_PIN_BIT = 2;
	localparam int SYSCLK_SEL_BIT = 0;
	localparam logic SYSCLK_SEL_RESET = 1'h0;
	localparam logic [3:0] BOOT_CODE_RESET = 4'h0;
	localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

	// ****************************************
	// Synchroniser and polling counts
	// ****************************************
	localparam int SYNC_W = 6;
	localparam logic [2:0] POLL_FIRST = 3'h0;
	localparam logic [2:0] POLL_LAST = 3'h6;

	// ****************************************
	// Boot sources, one-hot
	// ****************************************
	typedef enum logic [11:0] {
		SRC_NOR = 12'h001,
		SRC_NAND = 12'h002,
		SRC_UART = 12'h004,
		SRC_SPI = 12'h008,
		SRC_I2C = 12'h010,
		SRC_CARD0 = 12'h020,
		SRC_CARD1 = 12'h040,
		SRC_HOST = 12'h080,
		SRC_MSPI = 12'h100,
		SRC_USB = 12'h200,
		SRC_POLL = 12'h400,
		SRC_UART_USB = 12'h800
	} bssc_src_t;

	// ****************************************
	// Polling modes, one-hot
	// ****************************************
	typedef enum logic [2:0] {
		POLL_NONE = 3'h1,
		POLL_ONE = 3'h2,
		POLL_TWO = 3'h4
	} bssc_poll_t;

	// ****************************************
	// Decoded boot configuration
	// ****************************************
	typedef struct packed {
		bssc_src_t src;
		logic pll_x3;
		bssc_poll_t poll;
		logic [1:0] rate_sel;
	} bssc_boot_cfg_t;

	localparam bssc_boot_cfg_t BOOT_CFG_RESET = '{SRC_NOR, 1'h0, POLL_NONE, 2'h0};

endpackage

// ===== hw/bssc_boot_decode.sv
// Purpose: Decode the latched four-bit boot code into source, clock mode and rate
// Assumes: Code is stable once captured
// Notes: Purely combinational

`timescale 1ns/1ns

module bssc_boot_decode (
	input wire logic [3:0] code,
	output bssc_pkg::bssc_boot_cfg_t cfg
);

	// ****************************************
	// Code table
	// ****************************************
	always_comb begin
		cfg = bssc_pkg::BOOT_CFG_RESET;
		unique case (code)
			4'h0: cfg = '{bssc_pkg::SRC_NOR, 1'h0, bssc_pkg::POLL_NONE, 2'h0};
			4'h1: cfg = '{bssc_pkg::SRC_NAND, 1'h0, bssc_pkg::POLL_NONE, 2'h0};
			4'h2: cfg = '{bssc_pkg::SRC_UART, 1'h1, bssc_pkg::POLL_NONE, 2'h0};
			4'h3: cfg = '{bssc_pkg::SRC_UART, 1'h1, bssc_pkg::POLL_NONE, 2'h1};
			4'h4: cfg = '{bssc_pkg::SRC_UART, 1'h1, bssc_pkg::POLL_NONE, 2'h2};
			4'h5: cfg = '{bssc_pkg::SRC_SPI, 1'h1, bssc_pkg::POLL_NONE, 2'h0};
			4'h6: cfg = '{bssc_pkg::SRC_SPI, 1'h1, bssc_pkg::POLL_NONE, 2'h1};
			4'h7: cfg = '{bssc_pkg::SRC_POLL, 1'h0, bssc_pkg::POLL_TWO, 2'h0};
			4'h8: cfg = '{bssc_pkg::SRC_I2C, 1'h0, bssc_pkg::POLL_NONE, 2'h0};
			4'h9: cfg = '{bssc_pkg::SRC_CARD0, 1'h0, bssc_pkg::POLL_NONE, 2'h0};
			4'hA: cfg = '{bssc_pkg::SRC_CARD1, 1'h0, bssc_pkg::POLL_NONE, 2'h0};
			4'hB: cfg = '{bssc_pkg::SRC_POLL, 1'h0, bssc_pkg::POLL_ONE, 2'h0};
			4'hC: cfg = '{bssc_pkg::SRC_HOST, 1'h1, bssc_pkg::POLL_NONE, 2'h0};
			4'hD: cfg = '{bssc_pkg::SRC_MSPI, 1'h0, bssc_pkg::POLL_NONE, 2'h0};
			4'hE: cfg = '{bssc_pkg::SRC_MSPI, 1'h0, bssc_pkg::POLL_NONE, 2'h1};
			4'hF: cfg = '{bssc_pkg::SRC_USB, 1'h1, bssc_pkg::POLL_NONE, 2'h0};
		endcase
	end

endmodule // bssc_boot_decode

// ===== hw/bssc_boot_strap_clock_select.sv
// Purpose: Boot strap capture, boot decode, polling order and clock configuration register
// Assumes: AHB-Lite single word transfers, zero wait states, one system clock
// Notes: Strap and clock pins pass two flip-flops before use

`timescale 1ns/1ns

module bssc_boot_strap_clock_select (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [3:0] ext_addr_strap_pins,
	input wire logic [3:0] gpio_strap_pins,
	input wire logic strap_group_select,
	input wire logic clock_select_pin,
	input wire logic card_command_line,
	input wire logic poll_attempt_failed,
	input wire logic boot_image_found,
	output logic [3:0] boot_strap_code,
	output logic strap_captured,
	output bssc_pkg::bssc_boot_cfg_t boot_config,
	output logic sysclk_source_select,
	output logic poll_active,
	output bssc_pkg::bssc_src_t poll_source
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'h0;
			rst_n_q <= 1'h0;
		end else begin
			rst_meta_q <= 1'h1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [bssc_pkg::SYNC_W-1:0] pin_raw;
	logic [bssc_pkg::SYNC_W-1:0] pin_meta_q;
	logic [bssc_pkg::SYNC_W-1:0] pin_sync_q;
	logic [3:0] strap_sync;
	logic clk_pin_sync;
	logic card_cmd_sync;

	assign pin_raw = {clock_select_pin, card_command_line,
		strap_group_select ? gpio_strap_pins : ext_addr_strap_pins};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end

	assign strap_sync = pin_sync_q[3:0];
	assign card_cmd_sync = pin_sync_q[4];
	assign clk_pin_sync = pin_sync_q[5];

	// ****************************************
	// Strap capture
	// ****************************************
	logic captured_q;
	logic [3:0] code_q;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			captured_q <= 1'h0;
			code_q <= bssc_pkg::BOOT_CODE_RESET;
		end else if (!captured_q) begin
			captured_q <= 1'h1;
			code_q <= strap_sync;
		end
	end

	assign boot_strap_code = code_q;
	assign strap_captured = captured_q;

	// ****************************************
	// Boot decode
	// ****************************************
	bssc_pkg::bssc_boot_cfg_t cfg_dec;
	bssc_pkg::bssc_boot_cfg_t cfg_q;

	bssc_boot_decode u_decode (
		.code(code_q),
		.cfg(cfg_dec)
	);

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cfg_q <= bssc_pkg::BOOT_CFG_RESET;
		end else begin
			cfg_q <= cfg_dec;
		end
	end

	assign boot_config = cfg_q;

	// ****************************************
	// Polling order
	// ****************************************
	function automatic bssc_pkg::bssc_src_t poll_list(input bssc_pkg::bssc_poll_t mode, input logic [2:0] step);
		bssc_pkg::bssc_src_t src;
		src = bssc_pkg::SRC_NOR;
		case (step)
			3'h0: src = bssc_pkg::SRC_NOR;
			3'h1: src = bssc_pkg::SRC_NAND;
			3'h2: src = bssc_pkg::SRC_SPI;
			3'h3: src = bssc_pkg::SRC_I2C;
			3'h4: src = bssc_pkg::SRC_CARD0;
			3'h5: src = (mode == bssc_pkg::POLL_ONE) ? bssc_pkg::SRC_CARD1 : bssc_pkg::SRC_MSPI;
			3'h6: src = bssc_pkg::SRC_UART_USB;
			default: src = bssc_pkg::SRC_NOR;
		endcase
		return src;
	endfunction

	logic [2:0] poll_step_q;
	logic [2:0] poll_step_d;
	logic poll_found_q;
	logic poll_on;
	logic poll_on_card;
	logic poll_hold;
	logic poll_advance;
	bssc_pkg::bssc_src_t poll_cur;
	bssc_pkg::bssc_src_t poll_source_q;
	logic poll_active_q;

	assign poll_on = captured_q && (cfg_q.poll != bssc_pkg::POLL_NONE) && !poll_found_q;
	assign poll_cur = poll_list(cfg_q.poll, poll_step_q);
	assign poll_on_card = (poll_cur == bssc_pkg::SRC_CARD0) || (poll_cur == bssc_pkg::SRC_CARD1);
	assign poll_hold = poll_on_card && !card_cmd_sync;
	assign poll_advance = poll_on && poll_attempt_failed && !poll_hold;
	assign poll_step_d = !poll_advance ? poll_step_q :
		(poll_step_q == bssc_pkg::POLL_LAST) ? bssc_pkg::POLL_FIRST : poll_step_q + 3'h1;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			poll_step_q <= bssc_pkg::POLL_FIRST;
			poll_found_q <= 1'h0;
			poll_source_q <= bssc_pkg::SRC_NOR;
			poll_active_q <= 1'h0;
		end else begin
			poll_step_q <= poll_step_d;
			poll_found_q <= poll_found_q || (poll_on && boot_image_found);
			poll_source_q <= poll_cur;
			poll_active_q <= poll_on;
		end
	end

	assign poll_source = poll_source_q;
	assign poll_active = poll_active_q;

	// ****************************************
	// Bus address phase
	// ****************************************
	logic accept;
	logic sel_clk_cfg;
	logic sel_boot;
	logic wr_pend_q;
	logic wr_clk_cfg_q;
	logic sysclk_q;
	logic sysclk_now;
	logic [15:0] clk_cfg_word;
	logic [15:0] boot_word;
	logic [31:0] hrdata_d;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	assign accept = hsel && htrans[1] && hready && (hsize == 3'h2);
	assign sel_clk_cfg = (haddr == bssc_pkg::CLK_CFG_ADDR);
	assign sel_boot = (haddr == bssc_pkg::BOOT_STAT_ADDR);

	// Forward a write still in its data phase to a read right behind it
	assign sysclk_now = (wr_pend_q && wr_clk_cfg_q) ? hwdata[bssc_pkg::SYSCLK_SEL_BIT] : sysclk_q;
	assign clk_cfg_word = (16'(sysclk_now) << bssc_pkg::SYSCLK_SEL_BIT) |
		(16'(clk_pin_sync) << bssc_pkg::CLK_PIN_BIT);
	assign boot_word = 16'(code_q) << bssc_pkg::BOOT_CODE_LSB;
	assign hrdata_d = sel_clk_cfg ? {16'h0000, clk_cfg_word} :
		sel_boot ? {16'h0000, boot_word} : 32'h0000_0000;

	// ****************************************
	// Bus data phase and registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_pend_q <= 1'h0;
			wr_clk_cfg_q <= 1'h0;
			hrdata_q <= bssc_pkg::HRDATA_RESET;
			hreadyout_q <= 1'h1;
			hresp_q <= 1'h0;
		end else begin
			wr_pend_q <= accept && hwrite;
			wr_clk_cfg_q <= accept && hwrite && sel_clk_cfg;
			hreadyout_q <= 1'h1;
			hresp_q <= 1'h0;
			if (accept && !hwrite) begin
				hrdata_q <= hrdata_d;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sysclk_q <= bssc_pkg::SYSCLK_SEL_RESET;
		end else if (wr_pend_q && wr_clk_cfg_q) begin
			sysclk_q <= hwdata[bssc_pkg::SYSCLK_SEL_BIT];
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign sysclk_source_select = sysclk_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_q);

	a_capture_first_edge: assert property (!captured_q |=> captured_q)
		else $error("strap capture missed the first edge");
	a_capture_value: assert property ($rose(captured_q) |-> code_q == $past(strap_sync))
		else $error("captured code differs from strap pins");
	a_code_held: assert property (captured_q |=> $stable(code_q) [*8])
		else $error("boot code changed after capture");
	a_bypass_flash: assert property (captured_q && code_q <= 4'h1 |=> !cfg_q.pll_x3 &&
		(cfg_q.src == (code_q[0] ? bssc_pkg::SRC_NAND : bssc_pkg::SRC_NOR)))
		else $error("flash boot decode wrong");
	a_uart_times_three: assert property (cfg_q.src == bssc_pkg::SRC_UART |-> cfg_q.pll_x3 &&
		cfg_q.rate_sel == code_q[1:0] - 2'h2)
		else $error("uart boot decode wrong");
	a_times_three_set: assert property (captured_q && (code_q == 4'h5 || code_q == 4'h6 ||
		code_q == 4'hC || code_q == 4'hF) |=> cfg_q.pll_x3)
		else $error("times-three clock not selected");
	a_bypass_serial: assert property (captured_q && (code_q == 4'h8 || code_q == 4'h9 ||
		code_q == 4'hA) |=> !cfg_q.pll_x3)
		else $error("bypass not selected");
	a_mspi_rate: assert property (captured_q && (code_q == 4'hD || code_q == 4'hE) |=>
		cfg_q.src == bssc_pkg::SRC_MSPI && cfg_q.rate_sel == {1'h0, code_q[1]})
		else $error("serial port boot decode wrong");
	a_poll_card_hold: assert property (poll_on && poll_attempt_failed && poll_on_card && !card_cmd_sync
		|=> $stable(poll_step_q))
		else $error("poll left card while command line low");
	a_poll_wrap: assert property (poll_on && poll_attempt_failed && poll_step_q == 3'h6
		|=> poll_step_q == 3'h0 ##1 poll_source_q == bssc_pkg::SRC_NOR)
		else $error("poll did not retry from the start");
	a_poll_step_five: assert property (poll_step_q == 3'h5 && captured_q |-> poll_cur ==
		(cfg_q.poll == bssc_pkg::POLL_ONE ? bssc_pkg::SRC_CARD1 : bssc_pkg::SRC_MSPI))
		else $error("wrong sixth poll source");
	a_clk_pin_read: assert property (accept && !hwrite && sel_clk_cfg |=>
		hrdata[bssc_pkg::CLK_PIN_BIT] == $past(clk_pin_sync))
		else $error("clock pin state not read back");
	a_sysclk_write: assert property (accept && hwrite && sel_clk_cfg ##1 1'b1 |=>
		sysclk_source_select == $past(hwdata[bssc_pkg::SYSCLK_SEL_BIT]))
		else $error("clock source select not written");
	a_reserved_zero: assert property (hrdata[3] == 1'b0 && hrdata[1] == 1'b0 && hrdata[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");

	// ****************************************
	// Bus, polling, boot decode and capture checks
	// ****************************************
	a_bus_ready: assert property (hreadyout && !hresp)
		else $error("bus not ready or response not okay");
	a_boot_read: assert property (accept && !hwrite && sel_boot |=>
		hrdata == {23'h0, $past(code_q), 5'h00})
		else $error("boot status read wrong");
	a_unmapped_read: assert property (accept && !hwrite && !sel_clk_cfg && !sel_boot |=>
		hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_nonword_held: assert property (hsel && htrans[1] && hready && hsize != 3'h2 |=>
		$stable(hrdata))
		else $error("non-word access changed read data");
	a_sysclk_nonword: assert property (hsel && htrans[1] && hready && hsize != 3'h2 ##1 1'b1 |=>
		$stable(sysclk_source_select))
		else $error("non-word write changed clock select");
	a_poll_found_stop: assert property (poll_on && boot_image_found |=>
		##1 !poll_active)
		else $error("polling did not stop on image found");
	a_poll_advance: assert property (poll_on && poll_attempt_failed && !poll_hold &&
		poll_step_q != bssc_pkg::POLL_LAST |=> poll_step_q == $past(poll_step_q) + 3'h1)
		else $error("poll did not move to next source");
	a_no_poll: assert property (captured_q && cfg_q.poll == bssc_pkg::POLL_NONE |=>
		!poll_active)
		else $error("polling active outside polling mode");
	a_spi_rate: assert property (captured_q && (code_q == 4'h5 || code_q == 4'h6) |=>
		cfg_q.src == bssc_pkg::SRC_SPI && cfg_q.rate_sel == {1'h0, code_q[1]})
		else $error("spi boot decode wrong");
	a_card_src: assert property (captured_q && (code_q == 4'h9 || code_q == 4'hA) |=>
		cfg_q.src == (code_q[0] ? bssc_pkg::SRC_CARD0 : bssc_pkg::SRC_CARD1))
		else $error("card boot decode wrong");
	a_usb_host: assert property (captured_q && (code_q == 4'hC || code_q == 4'hF) |=>
		cfg_q.src == (code_q[0] ? bssc_pkg::SRC_USB : bssc_pkg::SRC_HOST))
		else $error("host or usb boot decode wrong");
	a_i2c_src: assert property (captured_q && code_q == 4'h8 |=> cfg_q.src == bssc_pkg::SRC_I2C)
		else $error("i2c boot decode wrong");
	a_captured_stays: assert property (captured_q |=> captured_q)
		else $error("capture flag dropped before reset");

	c_capture: cover property ($rose(captured_q));
	c_poll_wrap: cover property (poll_on && poll_attempt_failed && poll_step_q == 3'h6);
	c_card_hold: cover property (poll_on && poll_attempt_failed && poll_hold);
	c_clk_cfg_write: cover property (wr_pend_q && wr_clk_cfg_q);
	c_boot_read: cover property (accept && !hwrite && sel_boot);

endmodule // bssc_boot_strap_clock_select

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the boot strap and clock select block
// Assumes: One AHB-Lite slave, hready tied to hreadyout, zero wait states
// Notes: Every strap code is captured after its own reset and then decoded

`timescale 1ns/1ns

module tb_top;

	// ****************************************
	// Signals and design instance
	// ****************************************
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [3:0] ext_pins = 4'h0;
	logic [3:0] gpio_pins = 4'h0;
	logic group_sel = 1'h0;
	logic clk_pin = 1'h0;
	logic cmd_line = 1'h1;
	logic poll_fail = 1'h0;
	logic image_found = 1'h0;
	logic [3:0] boot_strap_code;
	logic strap_captured;
	bssc_pkg::bssc_boot_cfg_t boot_config;
	logic sysclk_source_select;
	logic poll_active;
	bssc_pkg::bssc_src_t poll_source;
	int err_total = 0;
	int checks = 0;
	logic [31:0] rd;
	bssc_pkg::bssc_boot_cfg_t ex;

	always #5 clk = ~clk;

	bssc_boot_strap_clock_select uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .ext_addr_strap_pins(ext_pins), .gpio_strap_pins(gpio_pins),
		.strap_group_select(group_sel), .clock_select_pin(clk_pin), .card_command_line(cmd_line),
		.poll_attempt_failed(poll_fail), .boot_image_found(image_found), .boot_strap_code(boot_strap_code),
		.strap_captured(strap_captured), .boot_config(boot_config), .sysclk_source_select(sysclk_source_select),
		.poll_active(poll_active), .poll_source(poll_source));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		if (err_total == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'h1 && ++n < 50);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'h1 && ++n < 50);
		d = hrdata;
		check("bus_resp", {30'h0, hreadyout, hresp}, 32'h0000_0002);
		if (n >= 50) begin
			err_total++;
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'h0;
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		repeat (6) @(posedge clk);
	endtask

	task automatic pulse(input logic [11:0] exp);
		@(posedge clk);
		poll_fail <= 1'h1;
		@(posedge clk);
		poll_fail <= 1'h0;
		@(posedge clk);
		#1 check("poll_source", {20'h0, poll_source}, {20'h0, exp});
		@(posedge clk);
	endtask

	function automatic bssc_pkg::bssc_boot_cfg_t exp_cfg(input logic [3:0] c);
		bssc_pkg::bssc_boot_cfg_t r;
		r = bssc_pkg::BOOT_CFG_RESET;
		r.pll_x3 = c inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hC, 4'hF};
		case (c)
			4'h1: r.src = bssc_pkg::SRC_NAND;
			4'h2, 4'h3, 4'h4: r.src = bssc_pkg::SRC_UART;
			4'h5, 4'h6: r.src = bssc_pkg::SRC_SPI;
			4'h7: r.poll = bssc_pkg::POLL_TWO;
			4'h8: r.src = bssc_pkg::SRC_I2C;
			4'h9: r.src = bssc_pkg::SRC_CARD0;
			4'hA: r.src = bssc_pkg::SRC_CARD1;
			4'hB: r.poll = bssc_pkg::POLL_ONE;
			4'hC: r.src = bssc_pkg::SRC_HOST;
			4'hD, 4'hE: r.src = bssc_pkg::SRC_MSPI;
			4'hF: r.src = bssc_pkg::SRC_USB;
			default: r.src = bssc_pkg::SRC_NOR;
		endcase
		if (c == 4'h7 || c == 4'hB) begin
			r.src = bssc_pkg::SRC_POLL;
		end
		if (c >= 4'h2 && c <= 4'h4) begin
			r.rate_sel = 2'(c - 4'h2);
		end
		if (c == 4'h6 || c == 4'hE) begin
			r.rate_sel = 2'h1;
		end
		return r;
	endfunction

	// ****************************************
	// Polling walk with card line hold and wrap
	// ****************************************
	task automatic poll_walk(input logic two);
		logic [11:0] order [7];
		order = '{12'h001, 12'h002, 12'h008, 12'h010, 12'h020, two ? 12'h100 : 12'h040, 12'h800};
		check("poll_active", {31'h0, poll_active}, 32'h1);
		check("poll_start", {20'h0, poll_source}, 32'h001);
		for (int i = 1; i <= 7; i++) begin
			if (order[i - 1] == 12'h020 || order[i - 1] == 12'h040) begin
				cmd_line <= 1'h0;
				repeat (3) @(posedge clk);
				pulse(order[i - 1]);
				cmd_line <= 1'h1;
				repeat (3) @(posedge clk);
			end
			pulse(order[i % 7]);
		end
		@(posedge clk);
		image_found <= 1'h1;
		@(posedge clk);
		image_found <= 1'h0;
		repeat (2) @(posedge clk);
		#1 check("poll_stop", {31'h0, poll_active}, 32'h0);
		pulse(12'h001);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		for (int k = 0; k < 16; k++) begin
			group_sel <= k[0];
			ext_pins <= k[0] ? ~k[3:0] : k[3:0];
			gpio_pins <= k[0] ? k[3:0] : ~k[3:0];
			clk_pin <= k[1];
			do_reset();
			ex = exp_cfg(k[3:0]);
			check("code", {28'h0, boot_strap_code}, {28'h0, k[3:0]});
			check("captured", {31'h0, strap_captured}, 32'h1);
			check("src", {20'h0, boot_config.src}, {20'h0, ex.src});
			check("poll", {29'h0, boot_config.poll}, {29'h0, ex.poll});
			check("rate", {30'h0, boot_config.rate_sel}, {30'h0, ex.rate_sel});
			if (k != 13 && k != 14) begin
				check("pll", {31'h0, boot_config.pll_x3}, {31'h0, ex.pll_x3});
			end
			ahb_xfer(1'h0, bssc_pkg::BOOT_STAT_ADDR, 32'h0, rd);
			check("status", rd, {23'h0, k[3:0], 5'h00});
			ahb_xfer(1'h0, bssc_pkg::CLK_CFG_ADDR, 32'h0, rd);
			check("ccfg_rst", rd, {29'h0, k[1], 2'h0});
			ahb_xfer(1'h1, bssc_pkg::CLK_CFG_ADDR, 32'h0000_0001, rd);
			ahb_xfer(1'h0, bssc_pkg::CLK_CFG_ADDR, 32'h0, rd);
			check("ccfg_pll", rd, {29'h0, k[1], 2'h1});
			check("sysclk_sel", {31'h0, sysclk_source_select}, 32'h1);
			ahb_xfer(1'h1, bssc_pkg::BOOT_STAT_ADDR, 32'h0000_FFFF, rd);
			ahb_xfer(1'h0, 32'h0000_7080, 32'h0, rd);
			check("unmapped", rd, 32'h0);
			if (k == 7 || k == 11) begin
				poll_walk(k == 7);
			end else begin
				check("no_poll", {31'h0, poll_active}, 32'h0);
			end
			ext_pins <= ~ext_pins;
			gpio_pins <= ~gpio_pins;
			group_sel <= ~k[0];
			clk_pin <= ~k[1];
			ahb_xfer(1'h1, bssc_pkg::CLK_CFG_ADDR, 32'h0000_0000, rd);
			repeat (4) @(posedge clk);
			ahb_xfer(1'h0, bssc_pkg::BOOT_STAT_ADDR, 32'h0, rd);
			check("status_hold", rd, {23'h0, k[3:0], 5'h00});
			check("code_hold", {28'h0, boot_strap_code}, {28'h0, k[3:0]});
			ahb_xfer(1'h0, bssc_pkg::CLK_CFG_ADDR, 32'h0, rd);
			check("ccfg_pin", rd, {29'h0, ~k[1], 2'h0});
			check("sysclk_byp", {31'h0, sysclk_source_select}, 32'h0);
			hsize <= 3'h1;
			ahb_xfer(1'h1, bssc_pkg::CLK_CFG_ADDR, 32'h0000_0001, rd);
			hsize <= 3'h2;
			ahb_xfer(1'h0, bssc_pkg::CLK_CFG_ADDR, 32'h0, rd);
			check("ccfg_size", rd, {29'h0, ~k[1], 2'h0});
		end
		close_out();
	end

	initial begin
		#400000;
		err_total++;
		close_out();
	end

endmodule // tb_top
